// ### design/sttc_line_ctrl.sv
/*
 * Line state and test control byte registers of an S/T transceiver, with the
 * datapath hooks they steer: state reporting, test tone, loopback, muting,
 * echo forcing and interchip link transmit gating.
 * Assumes all inputs except arst_n synchronous to clk and a deserialised control port.
 */
// Overview of operation
// - Received state field codes INFO 0, low, high, INFO X as 00, 01, 10, 11.
// - Network side: received INFO 1 reads low, INFO 3 reads high.
// - Terminal side: received INFO 2 reads low, INFO 4 reads high.
// - Anything undefined, test tone or undetermined signal, reads INFO X.
// - Hardware updates both state fields; software writes to them are ignored.
// - Transmitted state uses same code; sending the test tone reads INFO X.
// - Network side: sending INFO 2 reads low, INFO 4 reads high.
// - Terminal side: sending INFO 1 reads low, INFO 3 reads high.
// - Every bit clears on hardware or software reset.
// - External loopback bit loops both B channels back.
// - External loopback also loops D channel, network side only.
// - Test tone bit replaces line signalling with a 96 kHz square wave.
// - Star mode bit enables star configuration, network side only.
// - Input level bit picks CMOS thresholds at 0, TTL at 1.
// - Link clock code is speed MSB bit over external LSB in master mode.
// - B2 mute bit forces idle ones in the link transmit B2 slot.
// - B1 mute bit forces idle ones in the link transmit B1 slot.
// - Force echo bit sends every E bit as 0, network side only.
// - Terminal side force bit passes data when synced to INFO 4, not sending INFO 3.
// - Force bit moot when fully active; otherwise idle ones on link transmit.
`timescale 1ns/1ns
module sttc_line_ctrl
   import sttc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          soft_rst,
   input  wire logic          nt_mode,
   input  wire sttc_scp_req_t scp_req,
   output logic [7:0]         scp_rdata,
   input  wire sttc_info_t    rx_info,
   input  wire logic          rx_tone_seen,
   input  wire logic          rx_sync_info4,
   input  wire sttc_info_t    tx_info,
   input  wire sttc_pair_t    tx_pair_in,
   output sttc_pair_t         line_tx_pair,
   input  wire logic          e_bit_in,
   output logic               e_bit_out,
   input  wire logic          link_master,
   input  wire logic          link_speed_lsb,
   output logic [1:0]         link_clk_code,
   input  wire logic          link_tx_in,
   input  wire logic          link_b1_slot,
   input  wire logic          link_b2_slot,
   output logic               link_tx_bit,
   output logic               loop_b_en,
   output logic               loop_d_en,
   output logic               star_mode_en,
   output logic               ttl_levels_sel,
   output logic               ignore_info1,
   output logic               ignore_info3,
   output logic               tone_active
);

   logic [1:0] rst_sync_q;
   logic       rst_n;

   // Reset release through two flops; the first flop feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   logic [7:0] lstc_q, lstc_d;
   logic [7:0] rsva_q, rsva_d;
   logic [7:0] loc_q, loc_d;
   logic [7:0] rsvb_q, rsvb_d;
   logic [7:0] rdata_q, rdata_d;
   logic       tone_q, tone_d;
   logic       e_q, e_d;
   logic       ltx_q, ltx_d;
   sttc_pair_t pair_q, pair_d;

   // Address decode of the control port
   logic wr_lstc, wr_rsva, wr_loc, wr_rsvb;
   assign wr_lstc = scp_req.wr && (scp_req.addr == REG_LSTC);
   assign wr_rsva = scp_req.wr && (scp_req.addr == REG_RSVA);
   assign wr_loc  = scp_req.wr && (scp_req.addr == REG_LOC);
   assign wr_rsvb = scp_req.wr && (scp_req.addr == REG_RSVB);

   // Received state code; undetermined or stray INFO numbers fall to X
   logic       rx_is0, rx_low, rx_high;
   logic [1:0] rx_code;
   assign rx_is0  = rx_info.known && (rx_info.num == INFO_N0);
   assign rx_low  = rx_info.known && (rx_info.num == (nt_mode ? INFO_N1 : INFO_N2));
   assign rx_high = rx_info.known && (rx_info.num == (nt_mode ? INFO_N3 : INFO_N4));
   assign rx_code = rx_tone_seen ? CODE_X :
                    rx_is0       ? CODE_INFO0 :
                    rx_low       ? CODE_LOW :
                    rx_high      ? CODE_HIGH : CODE_X;

   // Transmitted state code; the tone overrides whatever activation sends
   logic       tx_is0, tx_low, tx_high;
   logic [1:0] tx_code;
   assign tx_is0  = tx_info.known && (tx_info.num == INFO_N0);
   assign tx_low  = tx_info.known && (tx_info.num == (nt_mode ? INFO_N2 : INFO_N1));
   assign tx_high = tx_info.known && (tx_info.num == (nt_mode ? INFO_N4 : INFO_N3));
   assign tx_code = lstc_q[LSTC_TONE] ? CODE_X :
                    tx_is0            ? CODE_INFO0 :
                    tx_low            ? CODE_LOW :
                    tx_high           ? CODE_HIGH : CODE_X;

   // Status field is always reloaded from hardware, so writes cannot stick
   logic [7:0] lstc_sw;
   assign lstc_sw = wr_lstc ? ((scp_req.wdata & LSTC_WMASK) | (lstc_q & ~LSTC_WMASK))
                            : lstc_q;
   always_comb begin
      lstc_d = lstc_sw;
      lstc_d[LSTC_RX_LSB +: 2] = rx_code;
      lstc_d[LSTC_TX_LSB +: 2] = tx_code;
   end

   assign rsva_d = wr_rsva ? scp_req.wdata : rsva_q;
   assign rsvb_d = wr_rsvb ? scp_req.wdata : rsvb_q;
   assign loc_d  = wr_loc ? (scp_req.wdata & LOC_WMASK) : loc_q;

   // Read mux; unmapped indices read zero so other byte banks can OR in
   logic [7:0] rd_mux;
   assign rd_mux = (scp_req.addr == REG_LSTC) ? lstc_q :
                   (scp_req.addr == REG_RSVA) ? rsva_q :
                   (scp_req.addr == REG_LOC)  ? loc_q  :
                   (scp_req.addr == REG_RSVB) ? rsvb_q : RESET_BYTE;
   assign rdata_d = scp_req.rd ? rd_mux : rdata_q;

   // Register bank; soft reset clears every bit like the hardware reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lstc_q  <= RESET_BYTE;
         rsva_q  <= RESET_BYTE;
         loc_q   <= RESET_BYTE;
         rsvb_q  <= RESET_BYTE;
         rdata_q <= RESET_BYTE;
      end else if (soft_rst) begin
         lstc_q  <= RESET_BYTE;
         rsva_q  <= RESET_BYTE;
         loc_q   <= RESET_BYTE;
         rsvb_q  <= RESET_BYTE;
         rdata_q <= RESET_BYTE;
      end else begin
         lstc_q  <= lstc_d;
         rsva_q  <= rsva_d;
         loc_q   <= loc_d;
         rsvb_q  <= rsvb_d;
         rdata_q <= rdata_d;
      end
   end
   assign scp_rdata = rdata_q;

   // Tone half period enable; held cleared while the tone is off
   logic tone_tick;
   sttc_tick #(
      .DIV (TONE_HALF_CYC)
   ) u_tone_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (!lstc_q[LSTC_TONE]),
      .tick  (tone_tick)
   );

   // Square wave replaces the normal pair drive while the tone bit is set
   assign tone_d = !lstc_q[LSTC_TONE] ? 1'b0 :
                   tone_tick          ? !tone_q : tone_q;
   assign pair_d = lstc_q[LSTC_TONE] ? sttc_pair_t'{p: tone_q, n: !tone_q} : tx_pair_in;

   // Echo bits are zeroed only on the network side
   logic force_e;
   assign force_e = nt_mode && loc_q[LOC_FORCE_E];
   assign e_d     = force_e ? 1'b0 : e_bit_in;

   // Link transmit: data only when fully active or forced while synced
   logic fully_active, forced_ok, pass_data, muted;
   assign fully_active = (tx_code == CODE_HIGH) && (rx_code == CODE_HIGH);
   assign forced_ok    = !nt_mode && loc_q[LOC_FORCE_TX] && rx_sync_info4
                         && (tx_code != CODE_HIGH);
   assign pass_data    = fully_active || forced_ok;
   assign muted        = (link_b1_slot && loc_q[LOC_MUTE_B1])
                       || (link_b2_slot && loc_q[LOC_MUTE_B2]);
   assign ltx_d        = (pass_data && !muted) ? link_tx_in : 1'b1;

   // Datapath flops; a soft reset parks only the tone flop, the others keep following their inputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tone_q <= 1'b0;
         pair_q <= '0;
         e_q    <= 1'b0;
         ltx_q  <= 1'b1;
      end else begin
         tone_q <= soft_rst ? 1'b0 : tone_d;
         pair_q <= pair_d;
         e_q    <= e_d;
         ltx_q  <= ltx_d;
      end
   end
   assign line_tx_pair = pair_q;
   assign e_bit_out    = e_q;
   assign link_tx_bit  = ltx_q;

   // Mode levels decoded straight from register bits
   assign loop_b_en      = lstc_q[LSTC_EXT_LB];
   assign loop_d_en      = lstc_q[LSTC_EXT_LB] && nt_mode;
   assign star_mode_en   = loc_q[LOC_STAR] && nt_mode;
   assign ttl_levels_sel = loc_q[LOC_TTL];
   assign link_clk_code  = link_master ? {loc_q[LOC_SPD_MSB], link_speed_lsb}
                                       : 2'h0;
   assign ignore_info1   = lstc_q[LSTC_NO_INFO1] && nt_mode;
   assign ignore_info3   = lstc_q[LSTC_NO_INFO3] && nt_mode;
   assign tone_active    = lstc_q[LSTC_TONE];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_RX_INFO0: assert property (
      (rx_is0 && !rx_tone_seen && !soft_rst) |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_INFO0))
      else $error("received INFO 0 not coded 00");

   AST_RX_NT: assert property (
      (nt_mode && rx_info.known && rx_info.num == INFO_N3 && !rx_tone_seen && !soft_rst)
      |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_HIGH))
      else $error("network side INFO 3 not coded high");

   AST_RX_TE: assert property (
      (!nt_mode && rx_info.known && rx_info.num == INFO_N2 && !rx_tone_seen && !soft_rst)
      |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_LOW))
      else $error("terminal side INFO 2 not coded low");

   AST_RX_X: assert property (
      ((rx_tone_seen || !rx_info.known) && !soft_rst) |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_X))
      else $error("undefined received signal not coded X");

   AST_STATUS_OWN: assert property (
      (wr_lstc && !soft_rst) |=> (lstc_q[5:2] == {$past(rx_code), $past(tx_code)}))
      else $error("software write reached status field");

   AST_TX_TONE: assert property (
      (lstc_q[LSTC_TONE] && !soft_rst) |=> (lstc_q[LSTC_TX_LSB +: 2] == CODE_X))
      else $error("tone transmission not coded X");

   AST_TX_MAP: assert property (
      (nt_mode && tx_info.known && tx_info.num == INFO_N4 && !lstc_q[LSTC_TONE] && !soft_rst)
      |=> (lstc_q[LSTC_TX_LSB +: 2] == CODE_HIGH))
      else $error("network side INFO 4 transmit not coded high");

   AST_TX_TE: assert property (
      (!nt_mode && tx_info.known && tx_info.num == INFO_N1 && !lstc_q[LSTC_TONE] && !soft_rst)
      |=> (lstc_q[LSTC_TX_LSB +: 2] == CODE_LOW))
      else $error("terminal side INFO 1 transmit not coded low");

   AST_SOFT_CLR: assert property (
      soft_rst |=> (loc_q == RESET_BYTE && rsva_q == RESET_BYTE && lstc_q == RESET_BYTE))
      else $error("soft reset left bits set");

   AST_LOOP_D: assert property (
      loop_d_en |-> (nt_mode && loop_b_en))
      else $error("D loopback outside network side loopback");

   AST_TONE_WAVE: assert property (
      (lstc_q[LSTC_TONE] && tone_tick && !soft_rst) ##1 lstc_q[LSTC_TONE]
      |=> (line_tx_pair.p != $past(line_tx_pair.p, 2)) && (line_tx_pair.n == !line_tx_pair.p))
      else $error("test tone not toggling on the pair");

   AST_MUTE: assert property (
      (link_b2_slot && loc_q[LOC_MUTE_B2]) |=> link_tx_bit)
      else $error("muted B2 slot carried data");

   AST_FORCE_E: assert property (
      (nt_mode && loc_q[LOC_FORCE_E]) |=> !e_bit_out)
      else $error("forced echo bit sent as one");

   AST_FORCE_TX: assert property (
      (forced_ok && !muted) |=> (link_tx_bit == $past(link_tx_in)))
      else $error("forced link transmit dropped data");

   AST_IDLE: assert property (
      (!fully_active && !forced_ok) |=> link_tx_bit)
      else $error("link transmit not idle while inactive");

   // Remaining side mappings of both state fields
   AST_RX_NT_LOW: assert property (
      (nt_mode && rx_info.known && rx_info.num == INFO_N1 && !rx_tone_seen && !soft_rst)
      |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_LOW))
      else $error("network side INFO 1 not coded low");

   AST_RX_TE_HIGH: assert property (
      (!nt_mode && rx_info.known && rx_info.num == INFO_N4 && !rx_tone_seen && !soft_rst)
      |=> (lstc_q[LSTC_RX_LSB +: 2] == CODE_HIGH))
      else $error("terminal side INFO 4 not coded high");

   AST_TX_NT_LOW: assert property (
      (nt_mode && tx_info.known && tx_info.num == INFO_N2 && !lstc_q[LSTC_TONE] && !soft_rst)
      |=> (lstc_q[LSTC_TX_LSB +: 2] == CODE_LOW))
      else $error("network side INFO 2 transmit not coded low");

   AST_TX_TE_HIGH: assert property (
      (!nt_mode && tx_info.known && tx_info.num == INFO_N3 && !lstc_q[LSTC_TONE] && !soft_rst)
      |=> (lstc_q[LSTC_TX_LSB +: 2] == CODE_HIGH))
      else $error("terminal side INFO 3 transmit not coded high");

   // A written control bit must reach its mode level on the next edge; then B1 muting and side checks of echo and link gating
   AST_LOOP_B: assert property (
      (wr_lstc && !soft_rst) |=> (loop_b_en == $past(scp_req.wdata[LSTC_EXT_LB])))
      else $error("loopback bit not applied");

   AST_TONE_BIT: assert property (
      (wr_lstc && !soft_rst) |=> (tone_active == $past(scp_req.wdata[LSTC_TONE])))
      else $error("tone bit not applied");

   AST_STAR: assert property (
      (wr_loc && !soft_rst) |=> (star_mode_en == ($past(scp_req.wdata[LOC_STAR]) && nt_mode)))
      else $error("star mode level wrong");

   AST_TTL: assert property (
      (wr_loc && !soft_rst) |=> (ttl_levels_sel == $past(scp_req.wdata[LOC_TTL])))
      else $error("input level select wrong");

   AST_CLK_MSB: assert property (
      (wr_loc && !soft_rst)
      |=> (link_clk_code[1] == (link_master && $past(scp_req.wdata[LOC_SPD_MSB]))))
      else $error("link clock code MSB wrong");

   AST_MUTE_B1: assert property (
      (link_b1_slot && loc_q[LOC_MUTE_B1]) |=> link_tx_bit)
      else $error("muted B1 slot carried data");

   AST_ECHO_TE: assert property (
      !nt_mode |=> (e_bit_out == $past(e_bit_in)))
      else $error("terminal side echo bit altered");

   AST_NT_NO_FORCE: assert property (
      (nt_mode && !fully_active) |=> link_tx_bit)
      else $error("network side passed data while not fully active");

   COV_TONE: cover property (lstc_q[LSTC_TONE] && tone_tick);
   COV_LOOP_NT: cover property (loop_d_en ##1 loop_b_en);
   COV_FORCED: cover property (forced_ok && !muted);
   COV_MUTE_B1: cover property (link_b1_slot && loc_q[LOC_MUTE_B1]);
   COV_SOFT: cover property (soft_rst ##1 !soft_rst);

endmodule

// ### design/sttc_pkg.sv
/*
 * Constants and carrier types for the S/T line state and test control bytes.
 * Assumes a 100 MHz system clock and byte registers addressed by their index.
 */
package sttc_pkg;

   // Clock and test tone timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int TONE_HZ       = 96_000;
   localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);   // Rounded down

   // Byte register indices on the serial control port
   localparam logic [3:0] REG_LSTC = 4'hB;   // line_state_test_control
   localparam logic [3:0] REG_RSVA = 4'hC;   // reserved_byte_a
   localparam logic [3:0] REG_LOC  = 4'hD;   // line_option_control
   localparam logic [3:0] REG_RSVB = 4'hE;   // reserved_byte_b

   // line_state_test_control bit positions
   localparam int LSTC_NO_INFO1 = 7;
   localparam int LSTC_NO_INFO3 = 6;
   localparam int LSTC_RX_LSB   = 4;   // Two-bit received state field
   localparam int LSTC_TX_LSB   = 2;   // Two-bit transmitted state field
   localparam int LSTC_EXT_LB   = 1;
   localparam int LSTC_TONE     = 0;

   // line_option_control bit positions
   localparam int LOC_STAR     = 7;
   localparam int LOC_TTL      = 6;
   localparam int LOC_SPD_MSB  = 5;
   localparam int LOC_MUTE_B2  = 4;
   localparam int LOC_MUTE_B1  = 3;
   localparam int LOC_FORCE_E  = 2;
   localparam int LOC_FORCE_TX = 1;

   // Reset values and write masks
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] LSTC_WMASK = 8'hC3;   // Status field is hardware owned
   localparam logic [7:0] LOC_WMASK  = 8'hFE;   // Bit 0 is reserved, reads zero

   // Two-bit line state codes
   localparam logic [1:0] CODE_INFO0 = 2'h0;
   localparam logic [1:0] CODE_LOW   = 2'h1;
   localparam logic [1:0] CODE_HIGH  = 2'h2;
   localparam logic [1:0] CODE_X     = 2'h3;

   // INFO numbers as reported by the line receiver and activation logic
   localparam logic [2:0] INFO_N0 = 3'h0;
   localparam logic [2:0] INFO_N1 = 3'h1;
   localparam logic [2:0] INFO_N2 = 3'h2;
   localparam logic [2:0] INFO_N3 = 3'h3;
   localparam logic [2:0] INFO_N4 = 3'h4;

   // One serial control port byte access after deserialisation
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } sttc_scp_req_t;

   // Line signal classification; known low means undetermined or foreign
   typedef struct packed {
      logic       known;
      logic [2:0] num;
   } sttc_info_t;

   // Line transmit pair drive levels
   typedef struct packed {
      logic p;
      logic n;
   } sttc_pair_t;

endpackage

// ### design/sttc_tick.sv
/*
 * Free running divider giving a one-cycle enable pulse every DIV clocks.
 * Assumes a synchronous clear and the already synchronised reset.
 */
`timescale 1ns/1ns
module sttc_tick #(
   parameter int DIV = 2
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clr,
   output logic      tick
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // Wrap at the last count, restart on clear so the first pulse is a full period
   assign tick  = (cnt_q == LAST) && !clr;
   assign cnt_d = (clr || tick) ? '0 : cnt_q + CW'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ### testbench/sttc_remote_model.sv
/*
 * Behavioural remote S/T transceiver at the far end of the line, as seen by
 * the receiver of the block under test.
 * Assumes the bench asks for a line level (0 INFO 0, 1 low, 2 high,
 * 3 not yet settled) and for the test tone.
 */
`timescale 1ns/1ns
module sttc_remote_model
   import sttc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       dut_nt,
   input  wire logic [1:0] level,
   input  wire logic       tone,
   output sttc_info_t      rx_info,
   output logic            rx_tone_seen,
   output logic            rx_sync_info4
);
   logic [2:0] num_lo;
   logic [2:0] num_hi;

   // The remote sits on the other side, so it only sends that side's INFOs
   assign num_lo = dut_nt ? INFO_N1 : INFO_N2;
   assign num_hi = dut_nt ? INFO_N3 : INFO_N4;

   // Defined levels before the first clock so the receiver never sees X
   initial begin
      rx_info       = '0;
      rx_tone_seen  = 1'b0;
      rx_sync_info4 = 1'b0;
   end

   // Unsettled or tone signals still carry a valid INFO number on purpose
   always @(negedge clk) begin
      rx_info.known <= (level != 2'h3) & ~tone;
      rx_info.num   <= (level == 2'h0) ? INFO_N0 : (level == 2'h1) ? num_lo : num_hi;
      rx_tone_seen  <= tone;
      rx_sync_info4 <= ~dut_nt & ~tone & (level == 2'h2);
   end
endmodule

// ### testbench/tb.sv
/*
 * Self-checking bench for the line state and test control byte registers.
 * Assumes the remote model on the line side and a 100 MHz clock.
 */
`timescale 1ns/1ns
module tb
   import sttc_pkg::*;
;
   logic          clk, arst_n, soft_rst, nt_mode, link_master, link_speed_lsb;
   logic          e_bit_in, e_bit_out, link_tx_in, link_b1_slot, link_b2_slot;
   logic          link_tx_bit, rx_tone_seen, rx_sync_info4, tone_rq;
   logic          loop_b_en, loop_d_en, star_mode_en, ttl_levels_sel;
   logic          ignore_info1, ignore_info3, tone_active;
   logic [1:0]    lvl, link_clk_code;
   logic [7:0]    scp_rdata;
   logic [31:0]   seed;
   sttc_scp_req_t req;
   sttc_info_t    rx_info, tx_info;
   sttc_pair_t    tx_pair_in, line_tx_pair;
   int            failures, n_checks;

   sttc_line_ctrl dut_u (.clk(clk), .arst_n(arst_n), .soft_rst(soft_rst),
      .nt_mode(nt_mode), .scp_req(req), .scp_rdata(scp_rdata), .rx_info(rx_info),
      .rx_tone_seen(rx_tone_seen), .rx_sync_info4(rx_sync_info4), .tx_info(tx_info),
      .tx_pair_in(tx_pair_in), .line_tx_pair(line_tx_pair), .e_bit_in(e_bit_in),
      .e_bit_out(e_bit_out), .link_master(link_master), .link_speed_lsb(link_speed_lsb),
      .link_clk_code(link_clk_code), .link_tx_in(link_tx_in), .link_b1_slot(link_b1_slot),
      .link_b2_slot(link_b2_slot), .link_tx_bit(link_tx_bit), .loop_b_en(loop_b_en),
      .loop_d_en(loop_d_en), .star_mode_en(star_mode_en), .ttl_levels_sel(ttl_levels_sel),
      .ignore_info1(ignore_info1), .ignore_info3(ignore_info3), .tone_active(tone_active));

   sttc_remote_model remote_u (.clk(clk), .dut_nt(nt_mode), .level(lvl), .tone(tone_rq),
      .rx_info(rx_info), .rx_tone_seen(rx_tone_seen), .rx_sync_info4(rx_sync_info4));

   // Clock
   initial begin
      clk = 1'b1;
      forever #5 clk = ~clk;
   end

   // Full 32 steps per call so successive draws are not shifted copies
   function logic [31:0] rnd();
      for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Expected codes: transmit from the side and the INFO number, receive from the level and the tone
   function automatic logic [1:0] tx_code(logic nt, logic [2:0] n, logic tone);
      if (tone) return CODE_X;
      if (n == INFO_N0) return CODE_INFO0;
      if (n == (nt ? INFO_N2 : INFO_N1)) return CODE_LOW;
      if (n == (nt ? INFO_N4 : INFO_N3)) return CODE_HIGH;
      return CODE_X;
   endfunction

   function automatic logic [1:0] rx_code(logic [1:0] lv, logic tone);
      if (tone || lv == 2'h3) return CODE_X;
      return (lv == 2'h0) ? CODE_INFO0 : (lv == 2'h1) ? CODE_LOW : CODE_HIGH;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One byte access; strobe held for exactly one sampling edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      req.rd = 1'b0;
      @(negedge clk);
      d = scp_rdata;
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog: the tests need about 20 us, so 300 us means a hang
   initial begin
      #300_000;
      failures++;
      give_verdict();
   end

   initial begin
      logic [7:0]  d;
      logic [31:0] r;
      logic [31:0] dir [3];
      logic        nt, sync, pass, exp_bit;
      logic [1:0]  rc, tc;
      int          k;
      dir = '{32'h0000_1402, 32'h0000_1400, 32'h0000_3400};
      {arst_n, soft_rst, nt_mode, link_master, link_speed_lsb, e_bit_in} = '0;
      {link_tx_in, link_b1_slot, link_b2_slot, tone_rq, lvl} = '0;
      req = '0;
      tx_info = '{1'b1, INFO_N0};
      tx_pair_in = '{1'b0, 1'b1};
      seed = 32'h3EA7;
      failures = 0;
      n_checks = 0;
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      // Reset values, and an unmapped index that keeps nothing
      wr(4'h0, 8'hFF);
      for (k = 0; k < 3; k++) begin
         rd(k == 0 ? REG_LSTC : k == 1 ? REG_LOC : 4'h0, d);
         chk(d, RESET_BYTE);
      end
      // Status field against random line states and random software writes
      for (k = 0; k < 48; k++) begin
         r = rnd();
         @(negedge clk);
         nt_mode = r[8];
         lvl = r[10:9];
         tone_rq = r[11];
         link_master = r[1];
         tx_info = '{1'b1, 3'(r[15:12] % 5)};
         wr(REG_LSTC, r[7:0]);
         repeat (2) @(negedge clk);
         rd(REG_LSTC, d);
         chk(d & 8'hC3, r[7:0] & 8'hC3);
         chk({6'h00, d[5:4]}, {6'h00, rx_code(lvl, tone_rq)});
         chk({6'h00, d[3:2]}, {6'h00, tx_code(nt_mode, tx_info.num, r[0])});
         chk({6'h00, loop_b_en, loop_d_en}, {6'h00, r[1], r[1] & r[8]});
         chk({6'h00, ignore_info1, ignore_info3}, {6'h00, r[7] & r[8], r[6] & r[8]});
      end
      // Option byte: readback, mode levels, link clock code, echo forcing
      for (k = 0; k < 16; k++) begin
         r = rnd();
         @(negedge clk);
         nt_mode = r[8];
         link_master = r[9];
         link_speed_lsb = r[10];
         e_bit_in = r[11];
         wr(REG_LOC, r[7:0]);
         rd(REG_LOC, d);
         chk(d, r[7:0] & LOC_WMASK);
         chk({4'h0, star_mode_en, ttl_levels_sel, link_clk_code},
             {4'h0, r[7] & r[8], r[6], r[9] ? {r[5], r[10]} : 2'h0});
         chk({7'h00, e_bit_out}, {7'h00, r[11] & ~(r[8] & r[2])});
      end
      // Interchip link transmit gating; first three draws are corner cases
      tone_rq = 1'b0;
      for (k = 0; k < 48; k++) begin
         r = (k < 3) ? dir[k] : rnd();
         nt = r[8];
         @(negedge clk);
         nt_mode = nt;
         lvl = (r[10:9] == 2'h3) ? 2'h2 : r[10:9];
         tx_info = '{1'b1, 3'(r[14:12] % 5)};
         wr(REG_LSTC, 8'h00);
         wr(REG_LOC, {3'b000, r[4], r[3], 1'b0, r[1], 1'b0});
         repeat (2) @(negedge clk);
         link_b1_slot = r[16];
         link_b2_slot = r[17];
         link_tx_in = r[18];
         @(negedge clk);
         rc = rx_code(lvl, 1'b0);
         tc = tx_code(nt, tx_info.num, 1'b0);
         sync = ~nt & (lvl == 2'h2);
         pass = (tc == CODE_HIGH && rc == CODE_HIGH) || (!nt && r[1] && sync && tc != CODE_HIGH);
         exp_bit = ((r[16] & r[3]) | (r[17] & r[4])) ? 1'b1 : (pass ? r[18] : 1'b1);
         chk({7'h00, link_tx_bit}, {7'h00, exp_bit});
      end
      // Software reset clears every byte, reserved storage included
      wr(REG_LSTC, 8'hC3);
      wr(REG_RSVA, 8'h5A);
      wr(REG_RSVB, 8'hA5);
      rd(REG_RSVA, d);
      chk(d, 8'h5A);
      @(negedge clk) soft_rst = 1'b1;
      @(negedge clk) soft_rst = 1'b0;
      for (k = 0; k < 4; k++) begin
         rd(REG_LSTC + 4'(k), d);
         chk(d & (k == 0 ? 8'hC3 : 8'hFF), RESET_BYTE);
      end
      // Test tone: half period and complementary pair
      wr(REG_LSTC, 8'h01);
      r = 0;
      d[0] = line_tx_pair.p;
      while (line_tx_pair.p === d[0] && r < 1200) begin
         @(negedge clk);
         r++;
      end
      d[0] = line_tx_pair.p;
      k = 0;
      while (line_tx_pair.p === d[0] && k < 1200) begin
         @(negedge clk);
         k++;
      end
      chk(8'(k), 8'(TONE_HALF_CYC));
      chk(8'(k >> 8), 8'(TONE_HALF_CYC >> 8));
      chk({7'h00, line_tx_pair.n}, {7'h00, ~line_tx_pair.p});
      chk({7'h00, tone_active}, 8'h01);
      wr(REG_LSTC, 8'h00);
      tx_pair_in = '{1'b1, 1'b1};
      repeat (2) @(negedge clk);
      chk({6'h00, line_tx_pair}, 8'h03);
      give_verdict();
   end
endmodule
